// File: src/logic_and_masking_unit.sv
// Logic and masking slice: register file, small data memory and the conjunction ops.
// Function
// - Paired form does conjunction and integer store together as one instruction.
// - Paired form reads all registers at cycle start, writes them at end.
// - Store source reads the register value from before the conjunction writes it.
// - Same memory location for source and store: read happens before write.
// - Paired form register fields are limited to registers 0 through 7.
// - Paired memory operands are indirect with displacement 0, 1 or an index.
// - Negative flag copies result MSB; zero flag set when result is zero.
// - Overflow and underflow cleared; carry and latched flags kept.
// - Overflow saturation mode never changes these results.
// - Two-operand form ANDs destination with inverted source, writes destination.
// - Two-operand mode field: register, direct, indirect, zero-extended immediate.
// - Two-operand inverse conjunction completes in one cycle.
// - Three-operand mode field picks which of the two sources are indirect.
// Assumes an Avalon-MM master with waitrequest; opcode fields live in two command words.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "logic_unit_regs.svh"
module logic_and_masking_unit (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic [`BUS_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [`DATA_W-1:0]     avs_writedata_i,
  output logic [`DATA_W-1:0]          avs_readdata_o,
  output logic                        avs_waitrequest_o,
  output logic                        busy_o
);
  // Command word A: [31:28] op, [27:26] mode, [24:20] dst, [19:15] src1, [14:10] src3, [9:8] disp.
  // Command word B: [27:24] base address of first memory operand, [19:16] second base,
  // [15:0] immediate, [3:0] direct address, [8:4] second register source.
  logic [`DATA_W-1:0]             opa_reg, opb_reg, idx0_reg, idx1_reg, result_reg;
  logic [`DATA_W-1:0]             regs_reg [`REG_COUNT];
  logic [`DATA_W-1:0]             mem_reg [`MEM_WORDS];
  logic [`ST_W-1:0]               stat_reg;
  logic                           ovm_reg;
  logic [`REG_IDX_W-1:0]          rfsel_reg;
  logic [`MEM_IDX_W-1:0]          memsel_reg;
  logic [`DATA_W-1:0]             readdata_reg;
  logic                           wait_reg;
  logic                           bad_reg;
  logic                           busy_reg;
  logic_unit_pkg::state_type      state_reg, state_next;

  operand_if opif ();
  conj_datapath u_dp (.op(opif));

  // Field extraction from the command words.
  logic_unit_pkg::op_type op_w;
  logic [1:0]             mode_w, disp_w;
  logic [`REG_IDX_W-1:0]  dst_w, src1_w, src3_w, src2r_w;
  logic [`MEM_IDX_W-1:0]  base1_w, base2_w, dir_w;
  logic [`IMM_W-1:0]      imm_w;
  assign op_w    = logic_unit_pkg::op_type'(opa_reg[`OP_HI:`OP_LO]);
  assign mode_w  = opa_reg[27:26];
  assign dst_w   = opa_reg[24:20];
  assign src1_w  = opa_reg[19:15];
  assign src3_w  = opa_reg[14:10];
  assign disp_w  = opa_reg[9:8];
  assign base1_w = opb_reg[27:24];
  assign base2_w = opb_reg[19:16];
  assign imm_w   = opb_reg[15:0];
  assign dir_w   = opb_reg[3:0];
  assign src2r_w = opb_reg[8:4];

  // Indirect displacement: zero, one or either index register.
  logic [`MEM_IDX_W-1:0] disp_val_w, ind1_w, ind2_w;
  assign disp_val_w = (disp_w == `DISP_ZERO) ? `MEM_IDX_W'(0) :
                      (disp_w == `DISP_ONE)  ? `MEM_IDX_W'(1) :
                      (disp_w == `DISP_IDX0) ? idx0_reg[`MEM_IDX_W-1:0] :
                                               idx1_reg[`MEM_IDX_W-1:0];
  assign ind1_w = base1_w + disp_val_w;
  assign ind2_w = base2_w + disp_val_w;

  // Operand legality: paired form only reaches the eight extended registers. The other forms
  // check only the register fields their mode really uses, because command word B fields overlap.
  logic pair_ok_w, inv2_ok_w, inv3_ok_w, op_ok_w, t1_ind_w, t2_ind_w;
  assign pair_ok_w = (src1_w <= `EXT_REG_LAST) && (dst_w <= `EXT_REG_LAST)
                     && (src3_w <= `EXT_REG_LAST);
  assign t1_ind_w  = (mode_w == `T_MODE_IND1) || (mode_w == `T_MODE_INDIND);
  assign t2_ind_w  = (mode_w == `T_MODE_IND2) || (mode_w == `T_MODE_INDIND);
  assign inv2_ok_w = (dst_w < `REG_IDX_W'(`REG_COUNT))
                     && ((mode_w != `SRC_MODE_REG) || (src1_w < `REG_IDX_W'(`REG_COUNT)));
  assign inv3_ok_w = (dst_w < `REG_IDX_W'(`REG_COUNT)) && (t1_ind_w || (src1_w < `REG_IDX_W'(`REG_COUNT)))
                     && (t2_ind_w || (src2r_w < `REG_IDX_W'(`REG_COUNT)));
  assign op_ok_w   = (op_w == logic_unit_pkg::OP_CONJ_ST) ? pair_ok_w :
                     (op_w == logic_unit_pkg::OP_INV2)    ? inv2_ok_w :
                     (op_w == logic_unit_pkg::OP_INV3)    ? inv3_ok_w : 1'b0;

  // Operand selection; all reads come from the state held at the start of execute.
  logic [`DATA_W-1:0] g_src_w, t_src1_w, t_src2_w, a_w, b_w;
  assign g_src_w  = (mode_w == `SRC_MODE_REG)    ? regs_reg[src1_w] :
                    (mode_w == `SRC_MODE_DIRECT) ? mem_reg[dir_w] :
                    (mode_w == `SRC_MODE_INDIR)  ? mem_reg[ind1_w] :
                                                   {{(`DATA_W-`IMM_W){1'b0}}, imm_w};
  assign t_src1_w = (mode_w == `T_MODE_IND1 || mode_w == `T_MODE_INDIND) ?
                    mem_reg[ind1_w] : regs_reg[src1_w];
  assign t_src2_w = (mode_w == `T_MODE_IND2 || mode_w == `T_MODE_INDIND) ?
                    mem_reg[ind2_w] : regs_reg[src2r_w];
  assign a_w = (op_w == logic_unit_pkg::OP_CONJ_ST) ? regs_reg[src1_w] :
               (op_w == logic_unit_pkg::OP_INV2)    ? regs_reg[dst_w] : t_src1_w;
  assign b_w = (op_w == logic_unit_pkg::OP_CONJ_ST) ? mem_reg[ind1_w] :
               (op_w == logic_unit_pkg::OP_INV2)    ? g_src_w : t_src2_w;
  assign opif.src_a    = a_w;
  assign opif.src_b    = b_w;
  assign opif.invert_b = (op_w != logic_unit_pkg::OP_CONJ_ST);

  // Flag update: sign and zero from the result, both overflow-type flags cleared, carry and
  // the two latched flags kept; the saturation mode bit is deliberately not an input here.
  logic [`ST_W-1:0] stat_new_w;
  assign stat_new_w = {stat_reg[`ST_LATCHED_UNF], stat_reg[`ST_LATCHED_OVF], opif.neg, opif.zero,
                       1'b0, 1'b0, stat_reg[`ST_C]};

  // Store half: source value is the pre-write register content.
  logic [`DATA_W-1:0] store_val_w;
  assign store_val_w = regs_reg[src3_w];

  // Bus decode. A write commits at the edge where the master sees waitrequest low; a read is
  // latched one edge earlier so that its data stands at that same edge.
  logic [4:0] word_w;
  logic       wr_w, rd_w, go_w, exec_w;
  assign word_w = avs_address_i[6:2];
  assign wr_w   = avs_write_i && !wait_reg;
  assign rd_w   = avs_read_i && wait_reg;
  assign go_w   = wr_w && (word_w == `REG_ADDR_GO) && (state_reg == logic_unit_pkg::ST_IDLE);
  assign exec_w = (state_reg == logic_unit_pkg::ST_EXEC) && op_ok_w;

  // Controller: one execute cycle per command.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      logic_unit_pkg::ST_IDLE: if (go_w) state_next = logic_unit_pkg::ST_EXEC;
      logic_unit_pkg::ST_EXEC: state_next = logic_unit_pkg::ST_DONE;
      logic_unit_pkg::ST_DONE: state_next = logic_unit_pkg::ST_IDLE;
      default: state_next = logic_unit_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) state_reg <= logic_unit_pkg::ST_IDLE;
    else state_reg <= state_next;
  end

  // Register file: software loads, conjunction writes at the end of execute.
  genvar gi;
  generate
    for (gi = 0; gi < `REG_COUNT; gi++) begin : g_rf
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) regs_reg[gi] <= '0;
        else if (exec_w && dst_w == `REG_IDX_W'(gi)) regs_reg[gi] <= opif.result;
        else if (wr_w && word_w == `REG_ADDR_RFDAT && rfsel_reg == `REG_IDX_W'(gi))
          regs_reg[gi] <= avs_writedata_i;
      end
    end
    // Data memory: store half writes after the conjunction has sampled it.
    for (gi = 0; gi < `MEM_WORDS; gi++) begin : g_mem
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) mem_reg[gi] <= '0;
        else if (exec_w && op_w == logic_unit_pkg::OP_CONJ_ST && ind2_w == `MEM_IDX_W'(gi))
          mem_reg[gi] <= store_val_w;
        else if (wr_w && word_w == `REG_ADDR_MEMDAT && memsel_reg == `MEM_IDX_W'(gi))
          mem_reg[gi] <= avs_writedata_i;
      end
    end
  endgenerate

  // Status and result capture; an illegal command is flagged and changes nothing.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_reg   <= `ST_RESET;
      result_reg <= '0;
      bad_reg    <= 1'b0;
    end else if (state_reg == logic_unit_pkg::ST_EXEC) begin
      bad_reg <= !op_ok_w;
      if (op_ok_w) begin
        stat_reg   <= stat_new_w;
        result_reg <= opif.result;
      end
    end else if (wr_w && word_w == `REG_ADDR_STAT) begin
      stat_reg <= avs_writedata_i[`ST_W-1:0];
    end
  end

  // Software-written configuration registers.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opa_reg <= '0; opb_reg <= '0; idx0_reg <= '0; idx1_reg <= '0;
      ovm_reg <= 1'b0; rfsel_reg <= '0; memsel_reg <= '0;
    end else if (wr_w) begin
      if (word_w == `REG_ADDR_OPA)    opa_reg <= avs_writedata_i;
      if (word_w == `REG_ADDR_OPB)    opb_reg <= avs_writedata_i;
      if (word_w == `REG_ADDR_IDX0)   idx0_reg <= avs_writedata_i;
      if (word_w == `REG_ADDR_IDX1)   idx1_reg <= avs_writedata_i;
      if (word_w == `REG_ADDR_OVM)    ovm_reg <= avs_writedata_i[0];
      if (word_w == `REG_ADDR_RFSEL)  rfsel_reg <= avs_writedata_i[`REG_IDX_W-1:0];
      if (word_w == `REG_ADDR_MEMSEL) memsel_reg <= avs_writedata_i[`MEM_IDX_W-1:0];
    end
  end

  // Read mux; unmapped words read zero.
  logic [`DATA_W-1:0] rd_mux_w;
  assign rd_mux_w =
    (word_w == `REG_ADDR_OPA)    ? opa_reg :
    (word_w == `REG_ADDR_OPB)    ? opb_reg :
    (word_w == `REG_ADDR_STAT)   ? {{(`DATA_W-`ST_W-2){1'b0}}, bad_reg,
                                    state_reg != logic_unit_pkg::ST_IDLE, stat_reg} :
    (word_w == `REG_ADDR_RESULT) ? result_reg :
    (word_w == `REG_ADDR_IDX0)   ? idx0_reg :
    (word_w == `REG_ADDR_IDX1)   ? idx1_reg :
    (word_w == `REG_ADDR_OVM)    ? {{(`DATA_W-1){1'b0}}, ovm_reg} :
    (word_w == `REG_ADDR_RFSEL)  ? {{(`DATA_W-`REG_IDX_W){1'b0}}, rfsel_reg} :
    (word_w == `REG_ADDR_RFDAT)  ? ((rfsel_reg < `REG_IDX_W'(`REG_COUNT)) ? regs_reg[rfsel_reg] : '0) :
    (word_w == `REG_ADDR_MEMSEL) ? {{(`DATA_W-`MEM_IDX_W){1'b0}}, memsel_reg} :
    (word_w == `REG_ADDR_MEMDAT) ? mem_reg[memsel_reg] : '0;

  // Bus slave: waitrequest high at idle, dropped for one cycle to complete each access.
  // Busy follows the next state so that the output pin comes straight from a flop.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_reg     <= 1'b1;
      readdata_reg <= '0;
      busy_reg     <= 1'b0;
    end else begin
      wait_reg <= !(wait_reg && (avs_read_i || avs_write_i));
      busy_reg <= (state_next != logic_unit_pkg::ST_IDLE);
      if (rd_w) readdata_reg <= rd_mux_w;
    end
  end

  logic [`DATA_W-1:0] rd_hold_w;
  assign rd_hold_w         = readdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o    = rd_hold_w;
  assign busy_o            = busy_reg;

  // Checks on the datapath, the execute timing and the bus answer.
  sequence s_exec_start;
    state_reg == logic_unit_pkg::ST_IDLE && go_w;
  endsequence
  sequence s_exec_done;
    state_reg == logic_unit_pkg::ST_EXEC ##1 state_reg == logic_unit_pkg::ST_DONE;
  endsequence
  a_exec_one_cycle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_exec_start |=> s_exec_done) else $error("execute did not take one cycle");
  a_flags_nz: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exec_w |=> stat_reg[`ST_N] == result_reg[`DATA_W-1] && stat_reg[`ST_Z] == (result_reg == '0))
    else $error("negative or zero flag wrong");
  a_flags_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exec_w |=> !stat_reg[`ST_V] && !stat_reg[`ST_UNDERFLOW]) else $error("overflow flags not cleared");
  a_flags_kept: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exec_w |=> $stable(stat_reg[`ST_C]) && $stable(stat_reg[`ST_LATCHED_OVF]) && $stable(stat_reg[`ST_LATCHED_UNF]))
    else $error("kept flag changed");
  a_dst_written: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exec_w |=> regs_reg[$past(dst_w)] == $past(opif.result)) else $error("destination not written");
  a_store_old: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exec_w && op_w == logic_unit_pkg::OP_CONJ_ST |=> mem_reg[$past(ind2_w)] == $past(store_val_w))
    else $error("store used wrong value");
  a_read_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exec_w && op_w == logic_unit_pkg::OP_CONJ_ST |=> result_reg == ($past(regs_reg[src1_w]) & $past(mem_reg[ind1_w])))
    else $error("memory read not before write");
  a_ext_limit: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_reg == logic_unit_pkg::ST_EXEC && op_w == logic_unit_pkg::OP_CONJ_ST && dst_w > `EXT_REG_LAST
    |=> $stable(stat_reg) && bad_reg) else $error("paired form used a high register");
  a_inv_result: assert property (@(posedge clk_i) disable iff (!rstn_i)
    exec_w && op_w == logic_unit_pkg::OP_INV2 |=> result_reg == ($past(regs_reg[dst_w]) & ~$past(g_src_w)))
    else $error("inverse conjunction wrong");
  a_bus_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wait_reg && (avs_read_i || avs_write_i) |=> !wait_reg) else $error("bus answer late");
endmodule

// File: src/logic_unit_regs.svh
// Constants for the logic and masking datapath slice.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LOGIC_UNIT_REGS_SVH
`define LOGIC_UNIT_REGS_SVH
`define DATA_W          32
`define REG_COUNT       28
`define REG_IDX_W       5
`define EXT_REG_LAST    5'h07
`define MEM_ADDR_W      24
`define MEM_WORDS       16
`define MEM_IDX_W       4
`define SRC_MODE_REG    2'h0
`define SRC_MODE_DIRECT 2'h1
`define SRC_MODE_INDIR  2'h2
`define SRC_MODE_IMM    2'h3
`define T_MODE_REGREG   2'h0
`define T_MODE_IND1     2'h1
`define T_MODE_IND2     2'h2
`define T_MODE_INDIND   2'h3
`define DISP_ZERO       2'h0
`define DISP_ONE        2'h1
`define DISP_IDX0       2'h2
`define DISP_IDX1       2'h3
`define IMM_W           16
`define ST_N            4
`define ST_Z            3
`define ST_V            2
`define ST_UNDERFLOW    1
`define ST_C            0
`define ST_LATCHED_OVF  5
`define ST_LATCHED_UNF  6
`define ST_W            7
`define ST_RESET        7'h00
`define REG_ADDR_OPA    5'h00
`define REG_ADDR_OPB    5'h01
`define REG_ADDR_GO     5'h02
`define REG_ADDR_STAT   5'h03
`define REG_ADDR_RESULT 5'h04
`define REG_ADDR_IDX0   5'h05
`define REG_ADDR_IDX1   5'h06
`define REG_ADDR_OVM    5'h07
`define REG_ADDR_RFSEL  5'h08
`define REG_ADDR_RFDAT  5'h09
`define REG_ADDR_MEMSEL 5'h0a
`define REG_ADDR_MEMDAT 5'h0b
`define OP_HI           31
`define OP_LO           28
`define BUS_ADDR_W      7
`endif

// File: src/logic_unit_pkg.sv
// Types shared by the logic and masking slice.
// Assumes the constants header is on the include path.
`include "logic_unit_regs.svh"
package logic_unit_pkg;
  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_CONJ_ST = 4'h1,
    OP_INV2    = 4'h2,
    OP_INV3    = 4'h3
  } op_type;
  typedef logic [`DATA_W-1:0] word_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } state_type;
endpackage

// File: src/operand_if.sv
// Operand carrier between the controller and the logic datapath.
// Assumes one clock domain; the controller drives, the datapath answers.
`timescale 1ns/1ps
`include "logic_unit_regs.svh"
interface operand_if;
  logic [`DATA_W-1:0] src_a;
  logic [`DATA_W-1:0] src_b;
  logic               invert_b;
  logic [`DATA_W-1:0] result;
  logic               neg;
  logic               zero;
  modport ctrl (output src_a, output src_b, output invert_b, input result, input neg, input zero);
  modport alu  (input src_a, input src_b, input invert_b, output result, output neg, output zero);
endinterface

// File: src/conj_datapath.sv
// Combinational conjunction with optional inverse of the second operand.
// Assumes operands are stable for the whole execute cycle.
`timescale 1ns/1ps
`include "logic_unit_regs.svh"
module conj_datapath (
  operand_if.alu op
);
  // Bitwise result and its sign and zero indications, with no saturation path.
  logic [`DATA_W-1:0] masked_b;
  assign masked_b  = op.invert_b ? ~op.src_b : op.src_b;
  assign op.result = op.src_a & masked_b;
  assign op.neg    = op.result[`DATA_W-1];
  assign op.zero   = (op.result == '0);
endmodule

// File: verification/logic_and_masking_unit_bench.sv
// Self-checking bench for the logic and masking slice, driven only over its register bus.
// Assumes the register map and command word layout that the design decodes.
`timescale 1ns/1ps
`include "logic_unit_regs.svh"
module logic_and_masking_unit_bench;
  logic                   clk_i;
  logic                   rstn_i;
  logic [`BUS_ADDR_W-1:0] avs_address_i;
  logic                   avs_read_i;
  logic                   avs_write_i;
  logic [`DATA_W-1:0]     avs_writedata_i;
  logic [`DATA_W-1:0]     avs_readdata_o;
  logic                   avs_waitrequest_o;
  logic                   busy_o;
  logic [`DATA_W-1:0]     rd_val;
  logic [`DATA_W-1:0]     opb2_tbl [0:3];
  int                     err_total;
  int                     num_checks;

  logic_and_masking_unit dut_u (
    .clk_i             (clk_i),
    .rstn_i            (rstn_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .busy_o            (busy_o)
  );

  // The 100 MHz core clock.
  always #5 clk_i = ~clk_i;

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("TB: mismatches %0d, checks %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access: request held until waitrequest is sampled low, read data taken at that edge.
  task automatic bus_xfer(input logic wr, input logic [4:0] idx, input logic [`DATA_W-1:0] data);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    avs_writedata_i <= data;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    rd_val = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // Register-file or memory access through a select word and a data word.
  task automatic put(input logic [4:0] sel, input logic [4:0] i, input logic [`DATA_W-1:0] v);
    bus_xfer(1'b1, sel, {27'h0, i});
    bus_xfer(1'b1, sel + 5'h01, v);
  endtask

  task automatic get(input logic [4:0] sel, input logic [4:0] i);
    bus_xfer(1'b1, sel, {27'h0, i});
    bus_xfer(1'b0, sel + 5'h01, 32'h0);
  endtask

  // Loads both command words, starts the command and polls the busy bit under a bound.
  task automatic run_cmd(input logic [`DATA_W-1:0] a, input logic [`DATA_W-1:0] b);
    int n;
    n = 0;
    bus_xfer(1'b1, `REG_ADDR_OPA, a);
    bus_xfer(1'b1, `REG_ADDR_OPB, b);
    bus_xfer(1'b1, `REG_ADDR_GO, 32'h1);
    @(posedge clk_i);
    check({31'h0, busy_o}, 32'h1);
    do begin
      bus_xfer(1'b0, `REG_ADDR_STAT, 32'h0);
      n++;
    end while (rd_val[7] !== 1'b0 && n < 50);
    if (rd_val[7] !== 1'b0) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // Packs the first command word.
  function automatic logic [`DATA_W-1:0] opa(input logic [3:0] op, input logic [1:0] md, input logic [4:0] d,
                                             input logic [4:0] s1, input logic [4:0] s3, input logic [1:0] dp);
    return {op, md, 1'b0, d, s1, s3, dp, 8'h00};
  endfunction

  // Main sequence: reset, then each operation with awkward operand choices.
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    err_total = 0;
    num_checks = 0;
    opb2_tbl = '{32'h0, 32'h3, 32'h0500_0000, 32'h0a02};
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    bus_xfer(1'b0, `REG_ADDR_STAT, 32'h0);
    check(rd_val, 32'h0);
    // Paired form: store source equals the conjunction target and both memory ends hit one word.
    put(`REG_ADDR_RFSEL, 5'd4, 32'ha323);
    put(`REG_ADDR_RFSEL, 5'd7, 32'h35);
    put(`REG_ADDR_MEMSEL, 5'd9, 32'h5c53);
    bus_xfer(1'b1, `REG_ADDR_IDX0, 32'h1);
    bus_xfer(1'b1, `REG_ADDR_OVM, 32'h1);
    bus_xfer(1'b1, `REG_ADDR_STAT, 32'h6f);
    run_cmd(opa(logic_unit_pkg::OP_CONJ_ST, 2'h0, 5'd7, 5'd4, 5'd7, `DISP_IDX0), 32'h0808_0000);
    get(`REG_ADDR_RFSEL, 5'd7);
    check(rd_val, 32'h3);
    get(`REG_ADDR_MEMSEL, 5'd9);
    check(rd_val, 32'h35);
    bus_xfer(1'b0, `REG_ADDR_STAT, 32'h0);
    check(rd_val, 32'h61);
    // Paired form through the second index: conjunction source and store reach different words.
    bus_xfer(1'b1, `REG_ADDR_IDX1, 32'h2);
    run_cmd(opa(logic_unit_pkg::OP_CONJ_ST, 2'h0, 5'd6, 5'd4, 5'd7, `DISP_IDX1), 32'h0700_0000);
    get(`REG_ADDR_RFSEL, 5'd6);
    check(rd_val, 32'h21);
    get(`REG_ADDR_MEMSEL, 5'd2);
    check(rd_val, 32'h3);
    // Two-operand form through every source mode, with a high register number as source.
    put(`REG_ADDR_RFSEL, 5'd25, 32'h0a02);
    put(`REG_ADDR_MEMSEL, 5'd3, 32'h0a02);
    put(`REG_ADDR_MEMSEL, 5'd6, 32'h0a02);
    bus_xfer(1'b1, `REG_ADDR_STAT, 32'h01);
    for (int m = 0; m < 4; m++) begin
      put(`REG_ADDR_RFSEL, 5'd20, 32'h0c2f);
      run_cmd(opa(logic_unit_pkg::OP_INV2, m[1:0], 5'd20, 5'd25, 5'd0, `DISP_ONE), opb2_tbl[m]);
      get(`REG_ADDR_RFSEL, 5'd20);
      check(rd_val, 32'h042d);
    end
    // Immediate is zero-extended: a negative result, then a zero result.
    put(`REG_ADDR_RFSEL, 5'd20, 32'hffff_ffff);
    run_cmd(opa(logic_unit_pkg::OP_INV2, 2'h3, 5'd20, 5'd0, 5'd0, `DISP_ZERO), 32'hffff);
    get(`REG_ADDR_RFSEL, 5'd20);
    check(rd_val, 32'hffff_0000);
    bus_xfer(1'b0, `REG_ADDR_STAT, 32'h0);
    check(rd_val, 32'h11);
    put(`REG_ADDR_RFSEL, 5'd20, 32'hffff);
    run_cmd(opa(logic_unit_pkg::OP_INV2, 2'h3, 5'd20, 5'd0, 5'd0, `DISP_ZERO), 32'hffff);
    bus_xfer(1'b0, `REG_ADDR_STAT, 32'h0);
    check(rd_val, 32'h09);
    // Three-operand form through every mode into a separate destination.
    put(`REG_ADDR_RFSEL, 5'd3, 32'h0c2f);
    put(`REG_ADDR_RFSEL, 5'd5, 32'h0a02);
    put(`REG_ADDR_MEMSEL, 5'd2, 32'h0c2f);
    put(`REG_ADDR_MEMSEL, 5'd10, 32'h0a02);
    for (int m = 0; m < 4; m++) begin
      put(`REG_ADDR_RFSEL, 5'd7, 32'h0);
      run_cmd(opa(logic_unit_pkg::OP_INV3, m[1:0], 5'd7, 5'd3, 5'd0, `DISP_ZERO), 32'h020a_0050);
      get(`REG_ADDR_RFSEL, 5'd7);
      check(rd_val, 32'h042d);
    end
    get(`REG_ADDR_RFSEL, 5'd3);
    check(rd_val, 32'h0c2f);
    // Paired form naming a register above 7 is refused and writes nothing.
    put(`REG_ADDR_RFSEL, 5'd8, 32'h1234);
    run_cmd(opa(logic_unit_pkg::OP_CONJ_ST, 2'h0, 5'd8, 5'd4, 5'd7, `DISP_ZERO), 32'h0808_0000);
    check({31'h0, rd_val[8]}, 32'h1);
    get(`REG_ADDR_RFSEL, 5'd8);
    check(rd_val, 32'h1234);
    // An unmapped word reads as zero.
    bus_xfer(1'b0, 5'h1f, 32'h0);
    check(rd_val, 32'h0);
    tally_and_finish();
  end
endmodule
